// ===== src/fast_pwm_pkg.sv
// Package: constants and types of the fast PWM timer
package fast_pwm_pkg;
   // ==========================================
   // Register map (word addresses on the plain port)
   localparam logic [3:0] addr_mode = 4'h0;
   localparam logic [3:0] addr_counter = 4'h1;
   localparam logic [3:0] addr_cmp_a = 4'h2;
   localparam logic [3:0] addr_cmp_b = 4'h3;
   localparam logic [3:0] addr_capture = 4'h4;
   localparam logic [3:0] addr_status = 4'h5;
   localparam logic [3:0] addr_mask = 4'h6;
   localparam logic [3:0] addr_pins = 4'h7;
   // ==========================================
   // Mode register fields
   localparam int mode_wgm_lsb = 0;
   localparam int mode_com_a_lsb = 4;
   localparam int mode_com_b_lsb = 6;
   localparam int mode_run_bit = 8;
   // ==========================================
   // Waveform modes
   localparam logic [3:0] wgm_fixed8 = 4'h5;
   localparam logic [3:0] wgm_fixed9 = 4'h6;
   localparam logic [3:0] wgm_fixed10 = 4'h7;
   localparam logic [3:0] wgm_capture_top = 4'he;
   localparam logic [3:0] wgm_cmp_a_top = 4'hf;
   localparam logic [15:0] top_fixed8 = 16'h00ff;
   localparam logic [15:0] top_fixed9 = 16'h01ff;
   localparam logic [15:0] top_fixed10 = 16'h03ff;
   localparam logic [15:0] count_max = 16'hffff;
   // ==========================================
   // Compare output modes
   localparam logic [1:0] com_off = 2'h0;
   localparam logic [1:0] com_noninv = 2'h2;
   localparam logic [1:0] com_inv = 2'h3;
   // ==========================================
   // Status bits
   localparam int st_overflow = 0;
   localparam int st_cmp_a = 1;
   localparam int st_cmp_b = 2;
   localparam int st_capture = 3;
   localparam int st_width = 4;
   // Reset values
   localparam logic [15:0] reset_word = 16'h0000;
   localparam logic [8:0] reset_mode = 9'h000;
   localparam logic [15:0] reset_capture = 16'hffff;
   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
endpackage

// ===== src/fast_pwm_timer_16bit.sv
// Fast PWM 16-bit timer with register port, flags and interrupt
// Operation
// - Count each tick up to fixed TOP 255, 511 or 1023 in modes 5-7.
// - Mode 14 uses capture register as TOP, mode 15 uses compare A.
// - Counter clears to zero on the tick that matches TOP.
// - Counter equal to a compare register sets that channel's flag.
// - Overflow flag sets every time the counter reaches TOP.
// - Compare A or capture flag sets with overflow when it defines TOP.
// - Fixed TOP modes mask compare writes above the TOP width.
// - Capture register TOP is unbuffered, writes act at once.
// - Counter above new TOP runs to maximum, wraps, then matches.
// - Compare A writes go into a buffer register.
// - Active compare A loads from buffer at the TOP match tick.
// - Output mode 2 gives non-inverted PWM, mode 3 inverted.
// - Waveform reaches the pin only while its direction bit is output.
// - Set or clear at compare match, opposite level at TOP to zero.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fast_pwm_timer_16bit #(
   parameter int prescale = 1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire fast_pwm_pkg::bus_req_t bus,
   output logic [15:0] rdata,
   output logic irq,
   output logic pwm_a_out,
   output logic pwm_a_oe,
   output logic pwm_b_out,
   output logic pwm_b_oe
);
   // Refuse a divider that the 17-bit tick counter cannot reach
   if (prescale < 1 || prescale > 65536) begin : g_bad_prescale
      $error("prescale out of range");
   end

   // ==========================================
   // Helpers
   function automatic logic [15:0] fixed_mask(input logic [3:0] wgm);
      case (wgm)
         fast_pwm_pkg::wgm_fixed8: fixed_mask = fast_pwm_pkg::top_fixed8;
         fast_pwm_pkg::wgm_fixed9: fixed_mask = fast_pwm_pkg::top_fixed9;
         fast_pwm_pkg::wgm_fixed10: fixed_mask = fast_pwm_pkg::top_fixed10;
         default: fixed_mask = fast_pwm_pkg::count_max;
      endcase
   endfunction

   function automatic logic next_pin(input logic [1:0] com, input logic cur,
                                     input logic match, input logic wrap);
      // Wrap drives the active level, match the idle one
      next_pin = cur;
      if (com == fast_pwm_pkg::com_noninv) begin
         if (wrap) next_pin = 1'b1;
         else if (match) next_pin = 1'b0;
      end else if (com == fast_pwm_pkg::com_inv) begin
         if (wrap) next_pin = 1'b0;
         else if (match) next_pin = 1'b1;
      end
   endfunction

   // ==========================================
   // Registers
   logic [8:0] mode;
   logic [15:0] counter_value;
   logic [15:0] cmp_a_buf;
   logic [15:0] compare_register_a;
   logic [15:0] compare_register_b;
   logic [15:0] capture_top_register;
   logic [fast_pwm_pkg::st_width-1:0] status;
   logic [fast_pwm_pkg::st_width-1:0] mask;
   logic [1:0] output_pin_direction;
   logic wave_a;
   logic wave_b;
   logic [16:0] div_count;
   logic tick;

   wire logic [3:0] waveform_mode_select = mode[fast_pwm_pkg::mode_wgm_lsb +: 4];
   wire logic [1:0] com_a = mode[fast_pwm_pkg::mode_com_a_lsb +: 2];
   wire logic [1:0] com_b = mode[fast_pwm_pkg::mode_com_b_lsb +: 2];
   wire logic run = mode[fast_pwm_pkg::mode_run_bit];
   wire logic wr = bus.wr;
   wire logic rd = bus.rd;

   // TOP selection per waveform mode
   logic [15:0] top;
   always_comb begin
      case (waveform_mode_select)
         fast_pwm_pkg::wgm_capture_top: top = capture_top_register;
         fast_pwm_pkg::wgm_cmp_a_top: top = compare_register_a;
         default: top = fixed_mask(waveform_mode_select);
      endcase
   end

   // Timer tick enable; counts only while run is set
   always_ff @(posedge mclk) begin
      if (reset || !run) begin
         div_count <= 17'h00000;
         tick <= 1'b0;
      end else if (div_count >= 17'(prescale - 1)) begin
         div_count <= 17'h00000;
         tick <= 1'b1;
      end else begin
         div_count <= div_count + 17'h00001;
         tick <= 1'b0;
      end
   end

   wire logic at_top = tick && (counter_value == top);
   wire logic match_a = tick && (counter_value == compare_register_a);
   wire logic match_b = tick && (counter_value == compare_register_b);
   wire logic cap_top = waveform_mode_select == fast_pwm_pkg::wgm_capture_top;
   wire logic a_top = waveform_mode_select == fast_pwm_pkg::wgm_cmp_a_top;
   wire logic cnt_wr = wr && bus.addr == fast_pwm_pkg::addr_counter;

   // Counter: above TOP it simply runs on past the maximum and wraps
   always_ff @(posedge mclk) begin
      if (reset) begin
         counter_value <= fast_pwm_pkg::reset_word;
      end else if (cnt_wr) begin
         counter_value <= bus.wdata;
      end else if (at_top) begin
         counter_value <= fast_pwm_pkg::reset_word;
      end else if (tick) begin
         counter_value <= counter_value + 16'h0001;
      end
   end

   // Compare and capture registers, compare A double buffered
   always_ff @(posedge mclk) begin
      if (reset) begin
         cmp_a_buf <= fast_pwm_pkg::reset_word;
         compare_register_a <= fast_pwm_pkg::reset_word;
         compare_register_b <= fast_pwm_pkg::reset_word;
         capture_top_register <= fast_pwm_pkg::reset_capture;
      end else begin
         if (wr && bus.addr == fast_pwm_pkg::addr_cmp_a) begin
            cmp_a_buf <= bus.wdata & fixed_mask(waveform_mode_select);
         end
         if (wr && bus.addr == fast_pwm_pkg::addr_cmp_b) begin
            compare_register_b <= bus.wdata & fixed_mask(waveform_mode_select);
         end
         if (wr && bus.addr == fast_pwm_pkg::addr_capture) begin
            capture_top_register <= bus.wdata;
         end
         if (at_top) begin
            compare_register_a <= cmp_a_buf;
         end
      end
   end

   // Mode, mask and pin direction
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode <= fast_pwm_pkg::reset_mode;
         mask <= '0;
         output_pin_direction <= 2'h0;
      end else if (wr) begin
         if (bus.addr == fast_pwm_pkg::addr_mode) begin
            mode <= bus.wdata[8:0];
         end else if (bus.addr == fast_pwm_pkg::addr_mask) begin
            mask <= bus.wdata[fast_pwm_pkg::st_width-1:0];
         end else if (bus.addr == fast_pwm_pkg::addr_pins) begin
            output_pin_direction <= bus.wdata[1:0];
         end
      end
   end

   // Sticky flags; a set in the clear cycle wins
   logic [fast_pwm_pkg::st_width-1:0] set_bits;
   logic [fast_pwm_pkg::st_width-1:0] clr_bits;
   always_comb begin
      set_bits = '0;
      set_bits[fast_pwm_pkg::st_overflow] = at_top;
      set_bits[fast_pwm_pkg::st_cmp_a] = match_a || (a_top && at_top);
      set_bits[fast_pwm_pkg::st_cmp_b] = match_b;
      set_bits[fast_pwm_pkg::st_capture] = cap_top && at_top;
      clr_bits = '0;
      if (wr && bus.addr == fast_pwm_pkg::addr_status) begin
         clr_bits = bus.wdata[fast_pwm_pkg::st_width-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         status <= '0;
      end else begin
         status <= (status & ~clr_bits) | set_bits;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((status & ~clr_bits) | set_bits) & mask);
      end
   end

   // Waveform generators; wrap beats a same-tick match at TOP
   always_ff @(posedge mclk) begin
      if (reset) begin
         wave_a <= 1'b0;
         wave_b <= 1'b0;
      end else begin
         wave_a <= next_pin(com_a, wave_a, match_a, at_top);
         wave_b <= next_pin(com_b, wave_b, match_b, at_top);
      end
   end

   // Pin drive only when direction is output
   always_ff @(posedge mclk) begin
      if (reset) begin
         pwm_a_out <= 1'b0;
         pwm_a_oe <= 1'b0;
         pwm_b_out <= 1'b0;
         pwm_b_oe <= 1'b0;
      end else begin
         pwm_a_oe <= output_pin_direction[0];
         pwm_b_oe <= output_pin_direction[1];
         pwm_a_out <= output_pin_direction[0] && wave_a && com_a != fast_pwm_pkg::com_off;
         pwm_b_out <= output_pin_direction[1] && wave_b && com_b != fast_pwm_pkg::com_off;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk) begin
      if (reset || !rd) begin
         rdata <= 16'h0000;
      end else if (bus.addr == fast_pwm_pkg::addr_mode) begin
         rdata <= {7'h00, mode};
      end else if (bus.addr == fast_pwm_pkg::addr_counter) begin
         rdata <= counter_value;
      end else if (bus.addr == fast_pwm_pkg::addr_cmp_a) begin
         rdata <= cmp_a_buf;
      end else if (bus.addr == fast_pwm_pkg::addr_cmp_b) begin
         rdata <= compare_register_b;
      end else if (bus.addr == fast_pwm_pkg::addr_capture) begin
         rdata <= capture_top_register;
      end else if (bus.addr == fast_pwm_pkg::addr_status) begin
         rdata <= {12'h000, status};
      end else if (bus.addr == fast_pwm_pkg::addr_mask) begin
         rdata <= {12'h000, mask};
      end else if (bus.addr == fast_pwm_pkg::addr_pins) begin
         rdata <= {14'h0000, output_pin_direction};
      end else begin
         rdata <= 16'h0000;
      end
   end

   // ==========================================
   // Assertions
   property p_wrap;
      @(posedge mclk) disable iff (reset) at_top && !cnt_wr |=> counter_value == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter not cleared after TOP");

   property p_incr;
      @(posedge mclk) disable iff (reset)
         tick && !at_top && !cnt_wr |=> counter_value == $past(counter_value) + 16'h0001;
   endproperty
   a_incr: assert property (p_incr) else $error("counter did not increment");

   property p_fixed8_top;
      @(posedge mclk) disable iff (reset)
         waveform_mode_select == 4'h5 |-> top == 16'h00ff;
   endproperty
   a_fixed8_top: assert property (p_fixed8_top) else $error("wrong 8-bit TOP");

   property p_ovf;
      @(posedge mclk) disable iff (reset) at_top |=> status[0];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag not set");

   property p_cap_flag;
      @(posedge mclk) disable iff (reset) at_top && cap_top |=> status[3] && status[0];
   endproperty
   a_cap_flag: assert property (p_cap_flag) else $error("capture flag missing");

   property p_cmp_flag;
      @(posedge mclk) disable iff (reset) match_b |=> status[2];
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare B flag missing");

   property p_buf_load;
      @(posedge mclk) disable iff (reset) at_top |=> compare_register_a == $past(cmp_a_buf);
   endproperty
   a_buf_load: assert property (p_buf_load) else $error("compare A not loaded");

   property p_buf_hold;
      @(posedge mclk) disable iff (reset) !at_top |=> $stable(compare_register_a);
   endproperty
   a_buf_hold: assert property (p_buf_hold) else $error("compare A moved early");

   property p_noninv;
      @(posedge mclk) disable iff (reset) at_top && com_a == 2'h2 |=> wave_a;
   endproperty
   a_noninv: assert property (p_noninv) else $error("non-inverted wave not set");

   property p_pin_off;
      @(posedge mclk) disable iff (reset) !output_pin_direction[0] |=> !pwm_a_out && !pwm_a_oe;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven as input");

   // ==========================================
   // Channel B waveform, write masking and TOP-defining flags
   property p_top_a_flag;
      @(posedge mclk) disable iff (reset)
         at_top && a_top |=> status[fast_pwm_pkg::st_cmp_a] && status[fast_pwm_pkg::st_overflow];
   endproperty
   a_top_a_flag: assert property (p_top_a_flag) else $error("no A flag at TOP");

   property p_mask_write;
      @(posedge mclk) disable iff (reset)
         wr && bus.addr == fast_pwm_pkg::addr_cmp_b
            && waveform_mode_select == fast_pwm_pkg::wgm_fixed8 |=> compare_register_b[15:8] == 8'h00;
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("compare write not masked");

   property p_cap_unbuf;
      @(posedge mclk) disable iff (reset)
         wr && bus.addr == fast_pwm_pkg::addr_capture
            |=> capture_top_register == $past(bus.wdata);
   endproperty
   a_cap_unbuf: assert property (p_cap_unbuf) else $error("capture write late");

   property p_inv_b;
      @(posedge mclk) disable iff (reset)
         at_top && com_b == fast_pwm_pkg::com_inv |=> !wave_b;
   endproperty
   a_inv_b: assert property (p_inv_b) else $error("inverted wave not low");

   property p_clear_b;
      @(posedge mclk) disable iff (reset)
         match_b && !at_top && com_b == fast_pwm_pkg::com_noninv |=> !wave_b;
   endproperty
   a_clear_b: assert property (p_clear_b) else $error("wave B not cleared at match");

   property p_oe_b;
      @(posedge mclk) disable iff (reset) output_pin_direction[1] |=> pwm_b_oe;
   endproperty
   a_oe_b: assert property (p_oe_b) else $error("pin B not driven");

   c_wrap: cover property (@(posedge mclk) disable iff (reset) at_top);
   c_match_a: cover property (@(posedge mclk) disable iff (reset) match_a && !at_top);
   c_max_wrap: cover property (@(posedge mclk) disable iff (reset)
      cap_top && tick && counter_value == 16'hffff);
   c_inv_b: cover property (@(posedge mclk) disable iff (reset)
      at_top && com_b == fast_pwm_pkg::com_inv);
   c_pwm_a: cover property (@(posedge mclk) disable iff (reset)
      match_a && com_a == fast_pwm_pkg::com_noninv);
endmodule // fast_pwm_timer_16bit
`default_nettype wire

// ===== verification/pwm_load.sv
// External load on one PWM pin: pulled-down pad that totals its high cycles
`timescale 1ns/1ns
`default_nettype none
module pwm_load (
   input wire logic mclk,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic clear,
   output logic [15:0] high_cycles
);
   // ==========================================
   // Pad level: the pull-down wins while nobody drives
   wire logic pad = pin_oe ? pin_out : 1'b0;
   // Tally every cycle that the pad is high since the last clear
   always_ff @(posedge mclk) begin
      if (clear) begin
         high_cycles <= 16'h0000;
      end else if (pad) begin
         high_cycles <= high_cycles + 16'h0001;
      end
   end
endmodule // pwm_load
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench of the fast PWM timer: register tasks and directed tests
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic mclk;
   logic reset;
   logic clear;
   fast_pwm_pkg::bus_req_t bus;
   logic [15:0] rdata;
   logic irq;
   logic pwm_a_out;
   logic pwm_a_oe;
   logic pwm_b_out;
   logic pwm_b_oe;
   logic [15:0] high_a;
   logic [15:0] high_b;
   logic [15:0] v;
   logic [3:0] wgm_tab [3] = '{4'h5, 4'h6, 4'h7};
   logic [15:0] top_tab [3] = '{16'h00ff, 16'h01ff, 16'h03ff};
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   localparam int cycle_limit = 20000;

   fast_pwm_timer_16bit #(.prescale(1)) fast_pwm_timer_16bit_inst (.mclk(mclk), .reset(reset),
      .bus(bus), .rdata(rdata), .irq(irq), .pwm_a_out(pwm_a_out), .pwm_a_oe(pwm_a_oe),
      .pwm_b_out(pwm_b_out), .pwm_b_oe(pwm_b_oe));
   pwm_load pwm_load_inst_a (.mclk(mclk), .pin_out(pwm_a_out), .pin_oe(pwm_a_oe),
      .clear(clear), .high_cycles(high_a));
   pwm_load pwm_load_inst_b (.mclk(mclk), .pin_out(pwm_b_out), .pin_oe(pwm_b_oe),
      .clear(clear), .high_cycles(high_b));

   // ==========================================
   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == cycle_limit) begin
         fail_count++;
         stop_test();
      end
   end

   // ==========================================
   // Register port tasks
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      bus <= '{a, d, 1'b0, 1'b0};
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge mclk);
      bus <= '{a, 16'h0000, 1'b0, 1'b0};
      #1 v = rdata;
   endtask
   task automatic rd_check(input string name, input logic [3:0] a, input logic [15:0] exp);
      rd(a);
      check(name, v, exp);
   endtask
   // Mode word: waveform mode, output mode of B with A off, run
   function automatic logic [15:0] mode(input logic [3:0] w, input logic [1:0] b, input logic r);
      return {7'h00, r, b, 2'h0, w};
   endfunction
   // Pin high time over exactly 256 cycles
   task automatic measure();
      @(posedge mclk);
      clear <= 1'b1;
      @(posedge mclk);
      clear <= 1'b0;
      repeat (256) @(posedge mclk);
      #1;
   endtask
   task automatic run_for(input logic [3:0] w, input int n);
      wr(4'h0, mode(w, 2'h0, 1'b1));
      repeat (n) @(posedge mclk);
      wr(4'h0, mode(w, 2'h0, 1'b0));
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      bus = '0;
      reset = 1'b1;
      clear = 1'b0;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      // Reset values, unmapped place ignores writes and reads zero
      wr(4'h8, 16'hffff);
      for (int a = 0; a < 9; a++) begin
         rd_check("reset value", 4'(a), (a == 4) ? fast_pwm_pkg::reset_capture : 16'h0000);
      end
      check("irq", {15'h0000, irq}, 16'h0000);
      check("oe", {14'h0000, pwm_a_oe, pwm_b_oe}, 16'h0000);
      $display("test reset done");
      // Fixed TOP modes: masking, wrap, flags
      wr(fast_pwm_pkg::addr_cmp_a, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         wr(4'h0, mode(wgm_tab[i], 2'h0, 1'b0));
         wr(fast_pwm_pkg::addr_cmp_b, 16'hfff0);
         rd_check("masked compare", fast_pwm_pkg::addr_cmp_b, 16'hfff0 & top_tab[i]);
         wr(fast_pwm_pkg::addr_cmp_b, 16'h0010);
         wr(fast_pwm_pkg::addr_status, 16'h000f);
         wr(fast_pwm_pkg::addr_counter, top_tab[i] - 16'h0005);
         run_for(wgm_tab[i], 40);
         rd(fast_pwm_pkg::addr_counter);
         check("wrapped", {15'h0000, v < 16'h0030}, 16'h0001);
         rd_check("fixed flags", fast_pwm_pkg::addr_status, 16'h0007);
      end
      $display("test fixed top done");
      // Capture register as TOP, unbuffered
      wr(fast_pwm_pkg::addr_capture, 16'h0040);
      wr(fast_pwm_pkg::addr_status, 16'h000f);
      wr(fast_pwm_pkg::addr_counter, 16'h0030);
      run_for(4'he, 45);
      rd_check("capture flags", fast_pwm_pkg::addr_status, 16'h000f);
      wr(fast_pwm_pkg::addr_status, 16'h000f);
      wr(fast_pwm_pkg::addr_counter, 16'h0050);
      run_for(4'he, 40);
      rd(fast_pwm_pkg::addr_counter);
      check("past top", {15'h0000, v > 16'h0050}, 16'h0001);
      rd_check("no overflow", fast_pwm_pkg::addr_status, 16'h0000);
      wr(fast_pwm_pkg::addr_counter, 16'hfff0);
      run_for(4'he, 40);
      rd(fast_pwm_pkg::addr_counter);
      check("max wrap", {15'h0000, v < 16'h0040}, 16'h0001);
      rd_check("wrap flags", fast_pwm_pkg::addr_status, 16'h0006);
      $display("test capture top done");
      // Compare A as TOP, PWM on channel B into the load
      wr(fast_pwm_pkg::addr_cmp_a, 16'h003f);
      wr(fast_pwm_pkg::addr_counter, 16'h0000);
      wr(fast_pwm_pkg::addr_pins, 16'h0003);
      wr(4'h0, mode(4'hf, fast_pwm_pkg::com_noninv, 1'b1));
      repeat (150) @(posedge mclk);
      measure();
      check("noninv high", high_b, 16'd68);
      check("off pin", high_a, 16'h0000);
      check("oe b", {15'h0000, pwm_b_oe}, 16'h0001);
      wr(4'h0, mode(4'hf, fast_pwm_pkg::com_inv, 1'b1));
      repeat (70) @(posedge mclk);
      measure();
      check("inv high", high_b, 16'd188);
      wr(fast_pwm_pkg::addr_pins, 16'h0001);
      measure();
      check("input pin", high_b, 16'h0000);
      check("oe b off", {15'h0000, pwm_b_oe}, 16'h0000);
      wr(fast_pwm_pkg::addr_pins, 16'h0003);
      wr(4'h0, mode(4'hf, fast_pwm_pkg::com_noninv, 1'b1));
      wr(fast_pwm_pkg::addr_cmp_a, 16'h007f);
      rd_check("buffer", fast_pwm_pkg::addr_cmp_a, 16'h007f);
      wr(fast_pwm_pkg::addr_status, 16'h000f);
      repeat (300) @(posedge mclk);
      measure();
      check("new period", high_b, 16'd34);
      rd(fast_pwm_pkg::addr_status);
      check("top a flags", v & 16'h0007, 16'h0007);
      $display("test compare top done");
      // Capture register as TOP, non-inverted A beside inverted B
      wr(fast_pwm_pkg::addr_cmp_a, 16'h0020);
      wr(fast_pwm_pkg::addr_capture, 16'h003f);
      wr(fast_pwm_pkg::addr_counter, 16'h0000);
      wr(4'h0, mode(4'he, fast_pwm_pkg::com_inv, 1'b1)
         | (16'(fast_pwm_pkg::com_noninv) << fast_pwm_pkg::mode_com_a_lsb));
      repeat (150) @(posedge mclk);
      measure();
      check("noninv a", high_a, 16'd132);
      check("inv b", high_b, 16'd188);
      check("oe a", {15'h0000, pwm_a_oe}, 16'h0001);
      $display("test two channels done");
      // Interrupt: raise, mask, clear
      wr(4'h0, mode(4'hf, 2'h0, 1'b0));
      wr(fast_pwm_pkg::addr_mask, 16'h0001);
      repeat (2) @(posedge mclk);
      #1 check("irq raised", {15'h0000, irq}, 16'h0001);
      wr(fast_pwm_pkg::addr_mask, 16'h0000);
      repeat (2) @(posedge mclk);
      #1 check("irq masked", {15'h0000, irq}, 16'h0000);
      wr(fast_pwm_pkg::addr_mask, 16'h0001);
      wr(fast_pwm_pkg::addr_status, 16'h0001);
      repeat (2) @(posedge mclk);
      #1 check("irq cleared", {15'h0000, irq}, 16'h0000);
      rd(fast_pwm_pkg::addr_status);
      check("w1c", v & 16'h0007, 16'h0006);
      $display("test interrupt done");
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
